//--- hw/bdma_count_pkg.sv
/*
  Constants for the bridge transfer channel zero count/control block:
  register indices, field positions, reset values, encodings.
  Assumes nothing of its surroundings.
*/
package bdma_count_pkg;
  // register byte addresses (plain register port, 8-bit address)
  localparam logic [7:0] ADDR_INIT_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_CUR_COUNT = 8'h18;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SIZE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;

  // initial count/control fields
  localparam int SRC_MSB = 31;
  localparam int SRC_LSB = 30;
  localparam int HS_MSB = 29;
  localparam int HS_LSB = 28;
  localparam int UNIT_MSB = 27;
  localparam int UNIT_LSB = 26;
  localparam int OTF_MSB = 25;
  localparam int OTF_LSB = 24;
  localparam int INTM_MSB = 23;
  localparam int INTM_LSB = 22;
  localparam int RELOAD_BIT = 21;
  localparam int EN_BIT = 20;
  localparam int CNT_W = 20;

  // fixed read values of the mode fields
  localparam logic [1:0] HANDSHAKE_MODE = 2'h0;
  localparam logic [1:0] UNIT_MODE = 2'h1;
  localparam logic [1:0] NO_ON_THE_FLY = 2'h0;

  // control register fields
  localparam int GATE_MSB = 3;
  localparam int GATE_LSB = 2;
  localparam int CMD_MSB = 1;
  localparam int CMD_LSB = 0;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_CANCEL = 2'h3;
  localparam logic [1:0] GATE_OPEN = 2'h0;

  // size register field and unit sizes
  localparam int SIZE_MSB = 31;
  localparam int SIZE_LSB = 30;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // request sources
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_AUDIO = 2'h1;
  localparam logic [1:0] SRC_UART = 2'h2;
  localparam logic [1:0] SRC_SYNC = 2'h3;

  // interrupt modes
  localparam logic [1:0] INTM_POLL = 2'h0;
  localparam logic [1:0] INTM_UNIT = 2'h2;
  localparam logic [1:0] INTM_TC = 2'h3;

  // interrupt status bits
  localparam int IRQ_UNIT_BIT = 0;
  localparam int IRQ_TC_BIT = 1;
  localparam int IRQ_CANCEL_BIT = 2;
  localparam int IRQ_W = 3;

  localparam logic [31:0] INIT_COUNT_RESET = 32'h0400_0000;
endpackage

//--- hw/bridge_dma_count_control.sv
/*
  Count and run control of bridge transfer channel zero: request
  selection, start/cancel, auto-reload, count decrement, interrupts.
  Assumes a bus engine that moves one unit per unit_go and answers
  with unit_done; requests are level inputs synchronous to clk_sys.
*/
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module bridge_dma_count_control
  import bdma_count_pkg::*;
#(
  // narrower counts ignore the field's upper bits on write
  parameter int COUNT_W = CNT_W
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic req_audio,
  input wire logic req_first_uart,
  input wire logic req_sync_serial_port,
  output logic unit_go,
  output logic [1:0] unit_size,
  input wire logic unit_done,
  output logic busy,
  output logic irq
);

  // *****************************************************************
  // state
  // *****************************************************************
  typedef enum logic [1:0] {IDLE, MOVE, WAIT} state_t;

  state_t state;
  logic [1:0] request_source_select;
  logic [1:0] interrupt_mode_select;
  logic auto_reload_enable;
  logic hw_enable;
  logic [COUNT_W-1:0] initial_byte_count;
  logic [COUNT_W-1:0] remaining_byte_count;
  logic [1:0] request_gate_select;
  logic [1:0] unit_size_select;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic sw_start;
  logic sw_cancel;
  logic periph_req;
  logic trigger;
  logic [COUNT_W-1:0] step;
  logic [COUNT_W-1:0] next_remaining;
  logic terminal;
  logic unit_end;
  logic [31-CNT_W:0] count_upper;

  // *****************************************************************
  // elaboration checks
  // *****************************************************************
  // a word step needs three bits, and the register field holds no more
  if (COUNT_W < 3 || COUNT_W > CNT_W)
  begin : g_count_width_check
    $error("count width out of range");
  end

  // *****************************************************************
  // decode
  // *****************************************************************
  logic wr_init;
  logic wr_ctrl;
  assign wr_init = reg_write && reg_addr == ADDR_INIT_COUNT;
  assign wr_ctrl = reg_write && reg_addr == ADDR_CONTROL;
  // commands never store: they act in the write cycle only
  assign sw_start = wr_ctrl && reg_wdata[CMD_MSB:CMD_LSB] == CMD_START;
  assign sw_cancel = wr_ctrl && reg_wdata[CMD_MSB:CMD_LSB] == CMD_CANCEL;

  always_comb
  begin
    case (request_source_select)
      SRC_AUDIO: periph_req = req_audio;
      SRC_UART: periph_req = req_first_uart;
      SRC_SYNC: periph_req = req_sync_serial_port;
      default: periph_req = 1'b0;
    endcase
  end

  // requests pass only with the gate open and enable set
  assign trigger = hw_enable && !sw_cancel &&
    (sw_start || (periph_req && request_gate_select == GATE_OPEN));

  always_comb
  begin
    case (unit_size)
      SIZE_HALF: step = COUNT_W'(3'h2);
      SIZE_WORD: step = COUNT_W'(3'h4);
      default: step = COUNT_W'(3'h1);
    endcase
  end

  // saturate so a miscounted value still reaches zero
  assign next_remaining = (remaining_byte_count > step) ?
    remaining_byte_count - step : '0;
  assign unit_end = state == MOVE && unit_done && !sw_cancel;
  assign terminal = unit_end && next_remaining == '0;

  // *****************************************************************
  // configuration registers
  // *****************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      request_source_select <= SRC_NONE;
      interrupt_mode_select <= INTM_POLL;
      auto_reload_enable <= 1'b0;
      initial_byte_count <= '0;
    end
    else if (wr_init)
    begin
      request_source_select <= reg_wdata[SRC_MSB:SRC_LSB];
      interrupt_mode_select <= reg_wdata[INTM_MSB:INTM_LSB];
      auto_reload_enable <= reg_wdata[RELOAD_BIT];
      initial_byte_count <= reg_wdata[COUNT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      request_gate_select <= GATE_OPEN;
    else if (wr_ctrl)
      request_gate_select <= reg_wdata[GATE_MSB:GATE_LSB];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      unit_size_select <= SIZE_BYTE;
    else if (reg_write && reg_addr == ADDR_SIZE)
      unit_size_select <= reg_wdata[SIZE_MSB:SIZE_LSB];
  end

  // held per unit: a size write in mid-unit would split it and miscount
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      unit_size <= SIZE_BYTE;
    else if (trigger && state != MOVE)
      unit_size <= unit_size_select;
  end

  // hardware enable; the write order itself is software's duty
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      hw_enable <= 1'b0;
    else if (sw_cancel)
      hw_enable <= 1'b0;
    else if (terminal && !auto_reload_enable)
      hw_enable <= 1'b0;
    else if (wr_init)
      hw_enable <= reg_wdata[EN_BIT];
  end

  // *****************************************************************
  // run control
  // *****************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state <= IDLE;
    else if (sw_cancel)
      state <= IDLE;
    else
    begin
      case (state)
        IDLE: if (trigger) state <= MOVE;
        MOVE: if (unit_done) state <= terminal ? IDLE : WAIT;
        // handshake: one unit per trigger
        WAIT: if (trigger) state <= MOVE;
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      remaining_byte_count <= '0;
    else if (state == IDLE && trigger)
      remaining_byte_count <= initial_byte_count;
    else if (terminal && auto_reload_enable)
      remaining_byte_count <= initial_byte_count;
    else if (unit_end)
      remaining_byte_count <= next_remaining;
  end

  assign unit_go = state == MOVE;
  assign busy = state != IDLE;

  // *****************************************************************
  // interrupts
  // *****************************************************************
  logic [IRQ_W-1:0] irq_set;
  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_UNIT_BIT] = unit_end && interrupt_mode_select == INTM_UNIT;
    irq_set[IRQ_TC_BIT] = terminal && interrupt_mode_select == INTM_TC;
    irq_set[IRQ_CANCEL_BIT] = sw_cancel && state != IDLE;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      irq_status <= '0;
    else if (reg_write && reg_addr == ADDR_IRQ_CLEAR)
      irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      irq_enable <= '0;
    else if (reg_write && reg_addr == ADDR_IRQ_ENABLE)
      irq_enable <= reg_wdata[IRQ_W-1:0];
  end

  assign irq = |(irq_status & irq_enable);

  // *****************************************************************
  // read port
  // *****************************************************************
  // both count views carry the same control fields above the count
  assign count_upper = {request_source_select, HANDSHAKE_MODE, UNIT_MODE, NO_ON_THE_FLY,
    interrupt_mode_select, auto_reload_enable, hw_enable};

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_read)
    begin
      case (reg_addr)
        ADDR_INIT_COUNT: reg_rdata <= {count_upper, CNT_W'(initial_byte_count)};
        ADDR_CUR_COUNT: reg_rdata <= {count_upper, CNT_W'(remaining_byte_count)};
        // command bits always read back as zero
        ADDR_CONTROL: reg_rdata <= {28'h0000000, request_gate_select, CMD_NONE};
        ADDR_SIZE: reg_rdata <= {unit_size_select, 30'h0};
        ADDR_IRQ_STATUS: reg_rdata <= {29'h0, irq_status};
        ADDR_IRQ_ENABLE: reg_rdata <= {29'h0, irq_enable};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
      reg_rdata <= 32'h00000000;
  end

endmodule

//--- tb/bdma_count_assertions.sv
/* Port checker for the count/control block.
   Bound to every instance of the top module; one clock domain. */
`timescale 1ns/1ps
module bdma_count_assertions
  import bdma_count_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic req_audio,
  input wire logic req_first_uart,
  input wire logic req_sync_serial_port,
  input wire logic unit_go,
  input wire logic [1:0] unit_size,
  input wire logic unit_done,
  input wire logic busy,
  input wire logic irq
);
  // ********
  // properties
  // ********
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic cwr = reg_write && reg_addr == ADDR_CONTROL && reg_wdata[1:0] == CMD_CANCEL;
  wire logic rq = req_audio || req_first_uart || req_sync_serial_port;
  sequence ends_s; unit_go && unit_done; endsequence
  sequence waits_s; unit_go && !unit_done && !cwr; endsequence
  chk_go_busy: assert property (unit_go |-> busy)
    else $error("unit_go without busy");
  chk_go_holds: assert property (waits_s |=> unit_go)
    else $error("unit_go dropped early");
  chk_one_unit: assert property (ends_s |=> !unit_go)
    else $error("unit_go held after done");
  chk_cancel_idle: assert property (cwr |=> !unit_go && !busy)
    else $error("cancel left channel busy");
  chk_fixed_modes: assert property ($past(reg_read) && $past(reg_addr) == ADDR_INIT_COUNT
    |-> reg_rdata[29:24] == {HANDSHAKE_MODE, UNIT_MODE, NO_ON_THE_FLY})
    else $error("fixed mode fields wrong");
  chk_cmd_clears: assert property ($past(reg_read) && $past(reg_addr) == ADDR_CONTROL
    |-> reg_rdata[1:0] == CMD_NONE)
    else $error("command bits not cleared");
  chk_no_trigger: assert property (!busy && !reg_write && !rq |=> !unit_go)
    else $error("unit without trigger");
  chk_irq_clear: assert property (reg_write && reg_addr == ADDR_IRQ_CLEAR
    && reg_wdata[2:0] == 3'h7 && !unit_done |=> !irq)
    else $error("irq stayed after clear");
  chk_size_steady: assert property (unit_go && $past(unit_go) |-> $stable(unit_size))
    else $error("unit size moved in a unit");
endmodule
bind bridge_dma_count_control bdma_count_assertions chk (.clk_sys(clk_sys), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .req_audio(req_audio), .req_first_uart(req_first_uart),
  .req_sync_serial_port(req_sync_serial_port), .unit_go(unit_go), .unit_size(unit_size),
  .unit_done(unit_done), .busy(busy), .irq(irq));

//--- tb/engine_model.sv
/* Bus engine stand-in: one unit_done pulse per unit after lag cycles.
   Assumes unit_go is a level held until done is seen. */
`timescale 1ns/1ps
module engine_model
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic unit_go,
  input wire logic [3:0] lag,
  output logic unit_done
);
  // ********
  // unit answer
  // ********
  logic [3:0] waited;
  // done set only from a standing unit_go; a cancel on the edge that raises done still leaves one pulse after unit_go drops
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      waited <= 4'h0;
      unit_done <= 1'b0;
    end
    else
    begin
      unit_done <= unit_go && !unit_done && waited >= lag;
      waited <= (unit_go && !unit_done) ? waited + 4'h1 : 4'h0;
    end
endmodule

//--- tb/testbench.sv
/* Self-checking bench for the count/control block.
   Drives registers and requests; engine_model answers the units. */
`timescale 1ns/1ps
module testbench
  import bdma_count_pkg::*;
;
  logic clk_sys = 0, resetn = 0, reg_write = 0, reg_read = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [3:1] req = 3'h0;
  logic [3:0] lag = 4'h0;
  logic unit_go, unit_done, busy, irq;
  logic [1:0] unit_size;
  int n_errors = 0, compares = 0;
  initial forever #25 clk_sys = ~clk_sys;
  bridge_dma_count_control dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .req_audio(req[1]), .req_first_uart(req[2]), .req_sync_serial_port(req[3]),
    .unit_go(unit_go), .unit_size(unit_size), .unit_done(unit_done), .busy(busy), .irq(irq));
  engine_model eng (.clk_sys(clk_sys), .resetn(resetn), .unit_go(unit_go), .lag(lag),
    .unit_done(unit_done));
  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // a gap cycle after each access keeps one driver step per edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    tick(1);
    reg_write <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    tick(1);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
    tick(1);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] s, m, input logic rl, en,
    input logic [19:0] n);
    return {s, HANDSHAKE_MODE, UNIT_MODE, NO_ON_THE_FLY, m, rl, en, n};
  endfunction
  task automatic setup(input logic [1:0] s, m, input logic rl, input logic [19:0] n);
    wr(ADDR_INIT_COUNT, cfg(s, m, rl, 1'b0, n));
    wr(ADDR_INIT_COUNT, cfg(s, m, rl, 1'b1, n));
  endtask
  task automatic start;
    wr(ADDR_CONTROL, {28'h0, GATE_OPEN, CMD_START});
  endtask
  // a unit that never completes counts as a mismatch
  task automatic wait_done;
    logic got;
    got = 1'b0;
    repeat (40)
    begin
      tick(1);
      if (unit_done === 1'b1)
      begin
        got = 1'b1;
        break;
      end
    end
    chk(got, 1'b1);
    tick(1);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset;
    rd(ADDR_INIT_COUNT, INIT_COUNT_RESET);
    wr(ADDR_CUR_COUNT, 32'hFFFF_FFFF);
    rd(ADDR_CUR_COUNT, INIT_COUNT_RESET);
    rd(8'h08, 32'h0);
    rd(ADDR_CONTROL, 32'h0);
  endtask
  task automatic t_disabled;
    wr(ADDR_INIT_COUNT, cfg(SRC_NONE, INTM_POLL, 1'b0, 1'b0, 20'h8));
    start;
    tick(3);
    chk(busy, 1'b0);
  endtask
  task automatic t_word;
    wr(ADDR_SIZE, {SIZE_WORD, 30'h0});
    wr(ADDR_IRQ_ENABLE, 32'h1);
    setup(SRC_NONE, INTM_UNIT, 1'b0, 20'h8);
    start;
    wait_done;
    chk(unit_size, SIZE_WORD);
    rd(ADDR_CUR_COUNT, cfg(SRC_NONE, INTM_UNIT, 1'b0, 1'b1, 20'h4));
    chk(irq, 1'b1);
    wr(ADDR_IRQ_CLEAR, 32'h7);
    chk(irq, 1'b0);
    start;
    wait_done;
    rd(ADDR_INIT_COUNT, cfg(SRC_NONE, INTM_UNIT, 1'b0, 1'b0, 20'h8));
  endtask
  task automatic t_reload;
    wr(ADDR_SIZE, {SIZE_HALF, 30'h0});
    wr(ADDR_IRQ_CLEAR, 32'h7);
    wr(ADDR_IRQ_ENABLE, 32'h2);
    setup(SRC_NONE, INTM_TC, 1'b1, 20'h4);
    start;
    wait_done;
    chk(irq, 1'b0);
    start;
    wait_done;
    chk(irq, 1'b1);
    tick(3);
    chk(busy, 1'b0);
    rd(ADDR_INIT_COUNT, cfg(SRC_NONE, INTM_TC, 1'b1, 1'b1, 20'h4));
    rd(ADDR_CUR_COUNT, cfg(SRC_NONE, INTM_TC, 1'b1, 1'b1, 20'h4));
    wr(ADDR_CONTROL, {28'h0, GATE_OPEN, CMD_CANCEL});
  endtask
  task automatic t_requests;
    wr(ADDR_SIZE, {SIZE_BYTE, 30'h0});
    for (int s = 1; s < 4; s++)
    begin
      setup(s[1:0], INTM_POLL, 1'b0, 20'h1);
      wr(ADDR_CONTROL, {28'h0, 2'h1, CMD_NONE});
      req <= 3'h1 << (s - 1);
      tick(4);
      chk(busy, 1'b0);
      req <= ~(3'h1 << (s - 1));
      wr(ADDR_CONTROL, {28'h0, GATE_OPEN, CMD_NONE});
      tick(2);
      chk(busy, 1'b0);
      req <= 3'h1 << (s - 1);
      wait_done;
      req <= 3'h0;
      rd(ADDR_INIT_COUNT, cfg(s[1:0], INTM_POLL, 1'b0, 1'b0, 20'h1));
    end
  endtask
  task automatic t_cancel;
    lag <= 4'hA;
    setup(SRC_NONE, INTM_POLL, 1'b0, 20'h8);
    start;
    chk(unit_go, 1'b1);
    wr(ADDR_CONTROL, {28'h0, GATE_OPEN, CMD_CANCEL});
    chk(busy, 1'b0);
    rd(ADDR_INIT_COUNT, cfg(SRC_NONE, INTM_POLL, 1'b0, 1'b0, 20'h8));
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h6);
    lag <= 4'h0;
  endtask
  task automatic conclude;
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    tick(12);
    resetn <= 1'b1;
    tick(1);
    t_reset;
    t_disabled;
    t_word;
    t_reload;
    t_requests;
    t_cancel;
    conclude;
  end
  initial
  begin
    #200us;
    n_errors++;
    conclude;
  end
endmodule
